// [pmwc_pkg.sv]
// power mode and wake-up control: shared constants and carrier types
// assumes an 8-bit special-function register port driven by the core
// Function
// - config bit 7 written one enters sleep
// - config bit 6 written one enters suspend, clock gated
// - config bit 5 written one clears all wake flags at once
// - config bit 4 read-only, set on reset pin falling edge
// - config bit 3 enables rtc fail wake, reads fail flag
// - config bit 2 enables rtc alarm wake, reads alarm flag
// - config bit 1 enables port match wake, reads match flag
// - config bit 0 enables comparator rising wake, reads its flag
// - flag bit 2 enables battery monitor wake, reads its flag
// - flag bit 0 enables pulse counter wake, reads its flag
// - no suspend or sleep and oscillator kept while any flag set
// - flags read zero for two clocks after suspend wake
// - mode bit 7 drives buffered rtc clock on port0 pin2
// - mode bit 6 enables wake request output on port0 pin3
// - mode bit 5 disables supply monitor; bits 4..0 read zero
// - power bit 2 selects battery (0) or converter output (1)
// - power bit 1 written one enters stop mode
// - power bit 0 enters idle; bits 7..3 general storage
// - flags set by events even when not enabled, also after wake
// - wake request output driven low on leaving sleep
// - a reset pin falling edge with monitor disabled gives full power-on reset
package pmwc_pkg;
    localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
    localparam logic [7:0] ADDR_UNIT_MODE     = 8'hB3;
    localparam logic [7:0] ADDR_UNIT_CONFIG   = 8'hB5;
    localparam logic [7:0] ADDR_UNIT_FLAGS    = 8'hB6;

    // config register fields
    localparam int CF_SLEEP   = 7;
    localparam int CF_SUSPEND = 6;
    localparam int CF_CLEAR   = 5;
    localparam int CF_RSTWAKE = 4;
    // flag register fields
    localparam int FL_BATTERY = 2;
    localparam int FL_PULSE   = 0;
    // mode register fields
    localparam int MD_RTC_OE  = 7;
    localparam int MD_WAKE_OE = 6;
    localparam int MD_SUPPLY_MONITOR_DISABLE  = 5;
    // power control fields
    localparam int PC_GF_LO   = 3;
    localparam int PC_POWER_SOURCE_SELECT  = 2;
    localparam int PC_STOP    = 1;
    localparam int PC_IDLE    = 0;

    localparam logic [7:0] RESET_MODE  = 8'h00;
    localparam logic [4:0] RESET_GF    = 5'h00;
    localparam logic [5:0] RESET_WAKE  = 6'h00;

    // flag blanking after suspend wake, in system clocks
    localparam int          BLANK_CLOCKS = 2;
    localparam logic [1:0]  BLANK_LOAD   = 2'(BLANK_CLOCKS);

    // wake source index: config bits 3..0 then battery, pulse
    localparam int NUM_SRC  = 6;
    localparam int SRC_BAT  = 4;
    localparam int SRC_PC   = 5;

    typedef enum logic [2:0] {
        PMWC_RUN     = 3'b000,
        PMWC_IDLE    = 3'b001,
        PMWC_STOP    = 3'b010,
        PMWC_SUSPEND = 3'b011,
        PMWC_SLEEP   = 3'b100
    } pmwc_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pmwc_sfr_req_t;

    typedef struct packed {
        logic [5:0] rise;       // one-cycle event pulses per source
        logic       reset_fall; // reset pin falling edge seen
    } pmwc_events_t;
endpackage

// [pmwc_edge.sv]
// per-bit rising edge detector for level event inputs
// assumes inputs already synchronous to the system clock
`timescale 1ns/10ps
module pmwc_edge #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] level_i,
    output logic      [WIDTH-1:0] rise_o
);
    logic [WIDTH-1:0] prev;

    // previous level per bit
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prev <= '0;
        end else begin
            prev <= level_i;
        end
    end

    // one pulse per bit on each low-to-high step
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            assign rise_o[g] = level_i[g] & ~prev[g];
        end
    endgenerate
endmodule

// [pmwc_power_mode_wakeup_control.sv]
// power mode sequencing, wake source enables and sticky wake flags
// assumes the core drives SFR_* for one cycle per access, events are sync
`timescale 1ns/10ps
module pmwc_power_mode_wakeup_control (
    input  wire logic       CORE_CLK_I,
    input  wire logic       RST_I,
    input  wire logic [7:0] SFR_ADDR_I,
    input  wire logic [7:0] SFR_WDATA_I,
    input  wire logic       SFR_WR_I,
    input  wire logic       SFR_RD_I,
    output logic      [7:0] SFR_RDATA_O,
    input  wire logic       RESET_PIN_N_I,
    input  wire logic       RTC_OSC_FAIL_I,
    input  wire logic       RTC_ALARM_I,
    input  wire logic       PORT_MATCH_I,
    input  wire logic       COMPARATOR_ZERO_I,
    input  wire logic       BATTERY_MONITOR_I,
    input  wire logic       PULSE_COUNTER_I,
    input  wire logic       RTC_CLOCK_I,
    input  wire logic       CORE_WAKE_I,
    output logic            SYS_CLOCK_GATE_O,
    output logic            OSC_STOP_O,
    output logic            LP_OSC_KEEP_O,
    output logic            REGULATOR_OFF_O,
    output logic            IDLE_O,
    output logic            STOP_O,
    output logic            SLEEP_O,
    output logic            PORT0_PIN2_O,
    output logic            PORT0_PIN2_OE_O,
    output logic            PORT0_PIN3_O,
    output logic            PORT0_PIN3_OE_O,
    output logic            SUPPLY_MONITOR_EN_O,
    output logic            FULL_POR_REQ_O,
    output logic            POWER_SOURCE_SELECT_O
);
    // all block state except the edge detector history in one packed struct
    typedef struct packed {
        pmwc_pkg::pmwc_mode_t mode;
        logic [5:0]           enable;     // wake source enables
        logic [5:0]           flag;       // sticky wake flags
        logic                 rst_flag;   // reset pin wake flag
        logic [7:0]           unit_mode;  // bits 7..5 kept, rest zero
        logic [4:0]           gf;         // general purpose storage
        logic                 power_source_select;
        logic [1:0]           blank;      // flag read blanking counter
        logic                 rst_pin_q;
        logic                 wake_req_n; // wake request line level
        logic [7:0]           rdata;
        logic                 por_req;
    } pmwc_state_t;

    pmwc_state_t         st;
    pmwc_state_t         next_st;
    pmwc_pkg::pmwc_sfr_req_t req;
    pmwc_pkg::pmwc_events_t  ev;
    logic [5:0]          level;
    logic [5:0]          rise;
    logic                any_flag;
    logic                wake_cause;

    assign req.addr  = SFR_ADDR_I;
    assign req.wdata = SFR_WDATA_I;
    assign req.wr    = SFR_WR_I;
    assign req.rd    = SFR_RD_I;

    // event levels in source order
    assign level = {PULSE_COUNTER_I, BATTERY_MONITOR_I, RTC_OSC_FAIL_I,
                    RTC_ALARM_I, PORT_MATCH_I, COMPARATOR_ZERO_I};

    pmwc_edge #(
        .WIDTH (pmwc_pkg::NUM_SRC)
    ) u_edge (
        .clk_i   (CORE_CLK_I),
        .rst_i   (RST_I),
        .level_i (level),
        .rise_o  (rise)
    );

    assign ev.rise       = rise;
    assign ev.reset_fall = st.rst_pin_q & ~RESET_PIN_N_I;

    // a set flag (any source) blocks deep modes and holds the oscillator
    assign any_flag   = (|st.flag) | st.rst_flag;
    // reset pin is always a wake source regardless of enables
    assign wake_cause = (|(ev.rise & st.enable)) | ev.reset_fall;

    always_comb begin
        next_st         = st;
        next_st.rst_pin_q = RESET_PIN_N_I;
        next_st.por_req = 1'b0;
        if (st.blank != 2'h0) begin
            next_st.blank = st.blank - 2'h1;
        end

        // flags track events even when disabled and while awake
        next_st.flag     = st.flag | ev.rise;
        next_st.rst_flag = st.rst_flag | ev.reset_fall;

        // register writes; mode strobes are not stored
        if (req.wr) begin
            case (req.addr)
                pmwc_pkg::ADDR_UNIT_CONFIG: begin
                    next_st.enable[3:0] = req.wdata[3:0];
                    if (req.wdata[pmwc_pkg::CF_CLEAR]) begin
                        // set beats clear: an event in this cycle survives
                        next_st.flag     = ev.rise;
                        next_st.rst_flag = ev.reset_fall;
                    end
                    // entry only with all flags clear, flags seen before write
                    if (!any_flag && st.mode == pmwc_pkg::PMWC_RUN) begin
                        if (req.wdata[pmwc_pkg::CF_SLEEP]) begin
                            next_st.mode = pmwc_pkg::PMWC_SLEEP;
                        end else if (req.wdata[pmwc_pkg::CF_SUSPEND]) begin
                            next_st.mode = pmwc_pkg::PMWC_SUSPEND;
                        end
                    end
                end
                pmwc_pkg::ADDR_UNIT_FLAGS: begin
                    next_st.enable[pmwc_pkg::SRC_BAT] = req.wdata[pmwc_pkg::FL_BATTERY];
                    next_st.enable[pmwc_pkg::SRC_PC]  = req.wdata[pmwc_pkg::FL_PULSE];
                end
                pmwc_pkg::ADDR_UNIT_MODE: begin
                    next_st.unit_mode = {req.wdata[7:5], 5'h00};
                end
                pmwc_pkg::ADDR_POWER_CONTROL: begin
                    next_st.gf     = req.wdata[7:pmwc_pkg::PC_GF_LO];
                    next_st.power_source_select = req.wdata[pmwc_pkg::PC_POWER_SOURCE_SELECT];
                    if (st.mode == pmwc_pkg::PMWC_RUN) begin
                        if (req.wdata[pmwc_pkg::PC_STOP]) begin
                            next_st.mode = pmwc_pkg::PMWC_STOP;
                        end else if (req.wdata[pmwc_pkg::PC_IDLE]) begin
                            next_st.mode = pmwc_pkg::PMWC_IDLE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // leaving low-power modes
        case (st.mode)
            pmwc_pkg::PMWC_SUSPEND: begin
                if (wake_cause) begin
                    next_st.mode  = pmwc_pkg::PMWC_RUN;
                    next_st.blank = pmwc_pkg::BLANK_LOAD;
                end
            end
            pmwc_pkg::PMWC_SLEEP: begin
                if (wake_cause) begin
                    next_st.mode       = pmwc_pkg::PMWC_RUN;
                    next_st.wake_req_n = 1'b0;
                end
            end
            pmwc_pkg::PMWC_IDLE, pmwc_pkg::PMWC_STOP: begin
                // core interrupt wake is decided outside; reset pin fall also wakes
                if (CORE_WAKE_I || ev.reset_fall) begin
                    next_st.mode = pmwc_pkg::PMWC_RUN;
                end
            end
            pmwc_pkg::PMWC_RUN: begin
            end
            default: begin
                next_st.mode = pmwc_pkg::PMWC_RUN;
            end
        endcase

        // request line released on next entry to sleep
        if (next_st.mode == pmwc_pkg::PMWC_SLEEP) begin
            next_st.wake_req_n = 1'b1;
        end

        // monitor off: a pin reset escalates to power-on reset
        if (st.unit_mode[pmwc_pkg::MD_SUPPLY_MONITOR_DISABLE] && ev.reset_fall) begin
            next_st.por_req = 1'b1;
        end

        // read data, registered; strobes and unused bits read zero
        next_st.rdata = 8'h00;
        if (req.rd) begin
            case (req.addr)
                pmwc_pkg::ADDR_UNIT_CONFIG: begin
                    if (st.blank == 2'h0) begin
                        next_st.rdata = {3'b000, st.rst_flag, st.flag[3:0]};
                    end
                end
                pmwc_pkg::ADDR_UNIT_FLAGS: begin
                    if (st.blank == 2'h0) begin
                        next_st.rdata = {5'h00, st.flag[pmwc_pkg::SRC_BAT], 1'b0,
                                         st.flag[pmwc_pkg::SRC_PC]};
                    end
                end
                pmwc_pkg::ADDR_UNIT_MODE: begin
                    next_st.rdata = st.unit_mode;
                end
                pmwc_pkg::ADDR_POWER_CONTROL: begin
                    next_st.rdata = {st.gf, st.power_source_select, 2'b00};
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    // single state register; full reset re-enables the supply monitor
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            st            <= '0;
            st.mode       <= pmwc_pkg::PMWC_RUN;
            st.enable     <= pmwc_pkg::RESET_WAKE;
            st.flag       <= pmwc_pkg::RESET_WAKE;
            st.unit_mode  <= pmwc_pkg::RESET_MODE;
            st.gf         <= pmwc_pkg::RESET_GF;
            st.rst_pin_q  <= 1'b1;
            st.wake_req_n <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // mode decode to power control outputs
    assign SYS_CLOCK_GATE_O  = (st.mode == pmwc_pkg::PMWC_SUSPEND) |
                               (st.mode == pmwc_pkg::PMWC_SLEEP);
    assign OSC_STOP_O        = SYS_CLOCK_GATE_O & ~any_flag;
    assign LP_OSC_KEEP_O     = any_flag;
    assign REGULATOR_OFF_O   = (st.mode == pmwc_pkg::PMWC_SLEEP);
    assign SLEEP_O           = REGULATOR_OFF_O;
    assign IDLE_O            = (st.mode == pmwc_pkg::PMWC_IDLE);
    assign STOP_O            = (st.mode == pmwc_pkg::PMWC_STOP);
    assign SFR_RDATA_O       = st.rdata;

    // auxiliary pins; rtc clock is a pass-through buffer
    assign PORT0_PIN2_OE_O   = st.unit_mode[pmwc_pkg::MD_RTC_OE];
    assign PORT0_PIN2_O      = RTC_CLOCK_I & st.unit_mode[pmwc_pkg::MD_RTC_OE];
    assign PORT0_PIN3_OE_O   = st.unit_mode[pmwc_pkg::MD_WAKE_OE];
    assign PORT0_PIN3_O      = st.wake_req_n;

    assign SUPPLY_MONITOR_EN_O   = ~st.unit_mode[pmwc_pkg::MD_SUPPLY_MONITOR_DISABLE];
    assign FULL_POR_REQ_O        = st.por_req;
    assign POWER_SOURCE_SELECT_O = st.power_source_select;
endmodule

// [pmwc_chk.sv]
// checker for the power mode and wake-up control top ports
// assumes one clock domain; bound by name at the foot of this file
`timescale 1ns/10ps
module pmwc_chk (
    input wire logic       CORE_CLK_I,
    input wire logic       RST_I,
    input wire logic [7:0] SFR_ADDR_I,
    input wire logic [7:0] SFR_WDATA_I,
    input wire logic       SFR_WR_I,
    input wire logic       SFR_RD_I,
    input wire logic [7:0] SFR_RDATA_O,
    input wire logic       RTC_CLOCK_I,
    input wire logic       SYS_CLOCK_GATE_O,
    input wire logic       OSC_STOP_O,
    input wire logic       LP_OSC_KEEP_O,
    input wire logic       SLEEP_O,
    input wire logic       IDLE_O,
    input wire logic       STOP_O,
    input wire logic       PORT0_PIN2_O,
    input wire logic       PORT0_PIN2_OE_O,
    input wire logic       PORT0_PIN3_O,
    input wire logic       SUPPLY_MONITOR_EN_O,
    input wire logic       POWER_SOURCE_SELECT_O
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    // low power entry is only legal from plain run
    wire run   = !(SLEEP_O || SYS_CLOCK_GATE_O || IDLE_O || STOP_O);
    wire cf_wr = SFR_WR_I && SFR_ADDR_I == 8'hB5;
    wire lp_wr = cf_wr && SFR_WDATA_I[7:6] != 2'b00 && run;
    a_sleep_entry: assert property (lp_wr && SFR_WDATA_I[7] && !LP_OSC_KEEP_O
        |=> SLEEP_O && SYS_CLOCK_GATE_O) else $error("sleep not entered");
    a_suspend_entry: assert property (lp_wr && SFR_WDATA_I[7:6] == 2'b01 && !LP_OSC_KEEP_O
        |=> SYS_CLOCK_GATE_O && !SLEEP_O) else $error("suspend not entered");
    a_entry_refused: assert property (lp_wr && LP_OSC_KEEP_O
        |=> !SLEEP_O && !SYS_CLOCK_GATE_O) else $error("entry with flag set");
    a_osc_kept: assert property (LP_OSC_KEEP_O |-> !OSC_STOP_O)
        else $error("oscillator stopped with flag set");
    a_blank_flags: assert property ($fell(SYS_CLOCK_GATE_O) && !$past(SLEEP_O) && SFR_RD_I
        && (SFR_ADDR_I == 8'hB5 || SFR_ADDR_I == 8'hB6)
        |=> SFR_RDATA_O == 8'h00) else $error("flags not blanked");
    a_wake_request: assert property ($fell(SLEEP_O) |-> !PORT0_PIN3_O)
        else $error("wake request not low");
    a_rtc_buffer: assert property (PORT0_PIN2_OE_O |-> PORT0_PIN2_O == RTC_CLOCK_I)
        else $error("rtc buffer mismatch");
    a_monitor_off: assert property (SFR_WR_I && SFR_ADDR_I == 8'hB3 && SFR_WDATA_I[5]
        |=> !SUPPLY_MONITOR_EN_O) else $error("monitor still enabled");
    a_source_select: assert property (SFR_WR_I && SFR_ADDR_I == 8'h87
        |=> POWER_SOURCE_SELECT_O == $past(SFR_WDATA_I[2])) else $error("source select");
    a_flag_unused: assert property (SFR_RD_I && SFR_ADDR_I == 8'hB6
        |=> SFR_RDATA_O[7:3] == 5'h00 && !SFR_RDATA_O[1]) else $error("unused flag bits");
    // main scenarios reached
    c_sleep: cover property (lp_wr && SFR_WDATA_I[7]);
    c_suspend_exit: cover property ($fell(SYS_CLOCK_GATE_O) && !$past(SLEEP_O));
    c_stop: cover property ($rose(STOP_O));
endmodule
bind pmwc_power_mode_wakeup_control pmwc_chk i_chk (.*);

// [testbench.sv]
// register-level testbench for power mode and wake-up control
// assumes one-cycle strobes and read data one cycle after the read edge
`timescale 1ns/10ps
module testbench;
    logic       clk   = 1'b0;
    logic       rst   = 1'b1;
    logic [7:0] addr  = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr    = 1'b0;
    logic       rd    = 1'b0;
    logic [6:0] ev    = 7'h00; // bit 6 is the reset pin, inverted
    logic       rtc   = 1'b0;
    logic       cwake = 1'b0;
    logic       por_seen = 1'b0;
    logic [7:0] rdata;
    logic gate, ostop, keep, regoff, idle, stop, sleep, p2, p2oe, p3, p3oe, mon, por, psel;
    int bad_count = 0;
    int check_count = 0;
    always #12.5 clk = ~clk;
    pmwc_power_mode_wakeup_control i_dut (
        .CORE_CLK_I(clk), .RST_I(rst), .SFR_ADDR_I(addr), .SFR_WDATA_I(wdata),
        .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_RDATA_O(rdata), .RESET_PIN_N_I(~ev[6]),
        .RTC_OSC_FAIL_I(ev[3]), .RTC_ALARM_I(ev[2]), .PORT_MATCH_I(ev[1]),
        .COMPARATOR_ZERO_I(ev[0]), .BATTERY_MONITOR_I(ev[4]), .PULSE_COUNTER_I(ev[5]),
        .RTC_CLOCK_I(rtc), .CORE_WAKE_I(cwake), .SYS_CLOCK_GATE_O(gate),
        .OSC_STOP_O(ostop), .LP_OSC_KEEP_O(keep), .REGULATOR_OFF_O(regoff),
        .IDLE_O(idle), .STOP_O(stop), .SLEEP_O(sleep), .PORT0_PIN2_O(p2),
        .PORT0_PIN2_OE_O(p2oe), .PORT0_PIN3_O(p3), .PORT0_PIN3_OE_O(p3oe),
        .SUPPLY_MONITOR_EN_O(mon), .FULL_POR_REQ_O(por), .POWER_SOURCE_SELECT_O(psel));
    // the power-on request is a single-cycle pulse, so latch it
    always @(posedge clk) if (por) por_seen <= 1'b1;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    // level high for one sampled cycle gives exactly one edge
    task automatic pulse(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        @(posedge clk);
        ev[i] <= 1'b0;
        tick(3);
    endtask
    task automatic core_wake();
        @(posedge clk);
        cwake <= 1'b1;
        @(posedge clk);
        cwake <= 1'b0;
        tick(3);
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // cut a hang short; the whole run needs well under 1000 cycles
    initial begin
        #100us;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped read, unused bits
        rd_chk(8'h87, 8'h00);
        rd_chk(8'hB5, 8'h00);
        rd_chk(8'h00, 8'h00);
        chk({mon, p3}, 8'h03);
        wr_reg(8'hB3, 8'hFF);
        rd_chk(8'hB3, 8'hE0);
        chk({p2oe, p3oe, mon}, 8'h06);
        for (int v = 1; v >= 0; v--) begin
            @(posedge clk);
            rtc <= v[0];
            #1;
            chk(p2, v[0]);
        end
        wr_reg(8'h87, 8'hFC);
        rd_chk(8'h87, 8'hFC);
        chk(psel, 8'h01);
        wr_reg(8'h87, 8'h00);
        wr_reg(8'hB6, 8'hFA);
        rd_chk(8'hB6, 8'h00);
        $display("registers done");
        // every source flags without being enabled; monitor still disabled
        wr_reg(8'hB5, 8'h00);
        for (int i = 0; i < 6; i++) pulse(i);
        rd_chk(8'hB5, 8'h0F);
        rd_chk(8'hB6, 8'h05);
        chk(keep, 8'h01);
        wr_reg(8'hB5, 8'h80);
        chk({sleep, gate}, 8'h00);
        wr_reg(8'hB5, 8'hA0);
        chk(sleep, 8'h00);
        rd_chk(8'hB5, 8'h00);
        rd_chk(8'hB6, 8'h00);
        pulse(6);
        rd_chk(8'hB5, 8'h10);
        chk(por_seen, 8'h01);
        wr_reg(8'hB5, 8'h20);
        $display("flags done");
        // sleep: a disabled source must not wake, an enabled one must
        wr_reg(8'hB5, 8'h81);
        chk({sleep, gate, regoff, ostop}, 8'h0F);
        pulse(1);
        chk(sleep, 8'h01);
        pulse(0);
        chk({sleep, p3}, 8'h00);
        rd_chk(8'hB5, 8'h03);
        wr_reg(8'hB5, 8'h20);
        $display("sleep done");
        // suspend, woken by the pulse counter, flags blanked at first
        wr_reg(8'hB6, 8'h01);
        wr_reg(8'hB5, 8'h40);
        chk({gate, sleep}, 8'h02);
        @(posedge clk);
        ev[5] <= 1'b1;
        @(posedge clk);
        // wake lands on this edge; read in each of the two clocks after it
        ev[5] <= 1'b0;
        addr <= 8'hB6;
        rd <= 1'b1;
        #1;
        chk(gate, 8'h00);
        @(posedge clk);
        #1;
        chk(rdata, 8'h00);
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, 8'h00);
        tick(3);
        rd_chk(8'hB6, 8'h01);
        wr_reg(8'hB5, 8'h20);
        $display("suspend done");
        // idle, then stop taking priority over idle
        wr_reg(8'h87, 8'h01);
        chk({stop, idle}, 8'h01);
        core_wake();
        wr_reg(8'h87, 8'h03);
        chk({stop, idle}, 8'h02);
        core_wake();
        chk({stop, idle}, 8'h00);
        rd_chk(8'h87, 8'h00);
        $display("idle stop done");
        // a second reset restores the supply monitor
        wr_reg(8'hB3, 8'h20);
        chk(mon, 8'h00);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk({mon, p3}, 8'h03);
        $display("reset done");
        end_sim();
    end
endmodule
